// >>> hdl/dcsw_cfg.svh
`ifndef DCSW_CFG_SVH
`define DCSW_CFG_SVH

// register byte offsets
`define DCSW_OFS_CTRL 8'h00
`define DCSW_OFS_REF 8'h04
`define DCSW_OFS_STAT 8'h08
`define DCSW_OFS_FREQ 8'h0C
`define DCSW_OFS_CFG 8'h10

// reset values
`define DCSW_CTRL_RST 16'h0000
`define DCSW_REF_RST 16'h0000
`define DCSW_CFG_RST 4'h0

// control word bit positions
`define DCSW_C_PRE_LO 0
`define DCSW_C_PRE_HI 1
`define DCSW_C_DCBRK 2
`define DCSW_C_COAST 3
`define DCSW_C_QSTOP 4
`define DCSW_C_FREEZE 5
`define DCSW_C_START 6
`define DCSW_C_RESET 7
`define DCSW_C_JOG 8
`define DCSW_C_VALID 10
`define DCSW_C_RELAY1 11
`define DCSW_C_RELAY2 12
`define DCSW_C_SET_LO 13
`define DCSW_C_SET_HI 14
`define DCSW_C_REV 15

// configuration register bit positions
`define DCSW_G_RELAY1 0
`define DCSW_G_RELAY2 1
`define DCSW_G_MULTI 2
`define DCSW_G_REVBUS 3

// status word bit positions
`define DCSW_S_CTL_RDY 0
`define DCSW_S_DRV_RDY 1
`define DCSW_S_STANDBY 2
`define DCSW_S_TRIP 3
`define DCSW_S_TRIPLOCK 6
`define DCSW_S_WARN 7
`define DCSW_S_AT_REF 8
`define DCSW_S_SERIAL 9
`define DCSW_S_IN_RANGE 10
`define DCSW_S_RUNNING 11
`define DCSW_S_VOLT 13
`define DCSW_S_CUR_LIM 14
`define DCSW_S_THERM 15

// frequency hold step on a speed-up or speed-down edge while the other input is low
`define DCSW_HOLD_STEP 16'h0001

`endif

// >>> hdl/dcsw_pkg.sv
package dcsw_pkg;
  typedef logic [7:0] dcsw_addr_t;
  typedef logic [15:0] dcsw_word_t;
  typedef logic [1:0] dcsw_sel_t;
  typedef logic [3:0] dcsw_cfg_t;
endpackage

// >>> hdl/dcsw_core.sv
`timescale 1ns/1ps
`include "dcsw_cfg.svh"
// Summary of operation
// - process words go control then reference inbound, status then frequency out.
// - control bits 01:00 pick one of four preset references.
// - control bit 02 low applies DC braking and stops the motor.
// - control bit 03 low coasts the motor; high permits start.
// - control bit 04 low performs a quick stop ramp to standstill.
// - control bit 05 low holds frequency; only speed up/down inputs change it.
// - while frequency is held, ramp stop from bit 06 is ignored.
// - control bit 06 low commands a ramp stop; high permits start.
// - a trip is reset only on a rising edge of control bit 07.
// - control bit 08 high runs the output at the jog frequency.
// - control word is used only when bit 10 is one.
// - bits 11 and 12 energise relays one and two when so configured.
// - bus time-out de-energises relays that serial control activated.
// - bits 14:13 select one of four setups when multi-setup is configured.
// - bit 15 reverses only when reversing accepts the bus source.
// - status bit 00 is one when ready, zero when tripped.
// - status bit 01 is one when ready but coasting by pin or command.
// - status bit 02 is one when a start command would start the motor.
// - status bit 03 is one while tripped awaiting reset.
// - status bits 04 and 05 unused; bit 06 flags trip lock.
// - status bit 07 is one while the warning input is high; warnings in bits 13 to 15 do not set it.
// - status bits 08 to 11 and 13 to 15 report drive conditions in documented order; bit 12 unused.
module dcsw_core (
  input wire logic clk,
  input wire logic rstn,
  input wire dcsw_pkg::dcsw_addr_t addr,
  input wire dcsw_pkg::dcsw_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output dcsw_pkg::dcsw_word_t rdata,
  input wire logic coast_pin_n,
  input wire logic speed_up_pin,
  input wire logic speed_down_pin,
  input wire logic tripped,
  input wire logic trip_lock,
  input wire logic warning,
  input wire logic speed_at_ref,
  input wire logic serial_ok,
  input wire logic freq_in_range,
  input wire logic running,
  input wire logic volt_warn,
  input wire logic cur_limit,
  input wire logic therm_warn,
  input wire logic bus_timeout,
  input wire dcsw_pkg::dcsw_word_t out_freq,
  output dcsw_pkg::dcsw_sel_t preset_sel,
  output logic dc_brake,
  output logic coast,
  output logic quick_stop,
  output logic freeze,
  output dcsw_pkg::dcsw_word_t held_freq,
  output logic ramp_stop,
  output logic trip_reset,
  output logic jog,
  output logic relay1,
  output logic relay2,
  output dcsw_pkg::dcsw_sel_t setup_sel,
  output logic reverse,
  output dcsw_pkg::dcsw_word_t ref_value
);
  import dcsw_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  function automatic logic hit(input dcsw_addr_t a, input dcsw_addr_t ofs);
    hit = (a == ofs);
  endfunction

  dcsw_word_t ctrl_r;
  dcsw_word_t ref_r;
  dcsw_cfg_t cfg_r;
  dcsw_word_t stat_r;
  dcsw_word_t rdata_r;
  logic ctrl_acc;
  logic rst_bit_r;

  // a word with the valid bit low is dropped whole
  assign ctrl_acc = wr && hit(addr, `DCSW_OFS_CTRL) &&
                    wdata[`DCSW_C_VALID];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `DCSW_CTRL_RST;
    end else if (ctrl_acc) begin
      ctrl_r <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_r <= `DCSW_REF_RST;
    end else if (wr && hit(addr, `DCSW_OFS_REF)) begin
      ref_r <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= `DCSW_CFG_RST;
    end else if (wr && hit(addr, `DCSW_OFS_CFG)) begin
      cfg_r <= wdata[3:0];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `DCSW_OFS_CTRL: rdata_r <= ctrl_r;
        `DCSW_OFS_REF: rdata_r <= ref_r;
        `DCSW_OFS_STAT: rdata_r <= stat_r;
        `DCSW_OFS_FREQ: rdata_r <= out_freq;
        `DCSW_OFS_CFG: rdata_r <= {12'h000, cfg_r};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change counts once stages two and three agree
  logic [2:0] coast_s_r;
  logic [2:0] up_s_r;
  logic [2:0] dn_s_r;
  logic coast_pin_low_r;
  logic up_lvl_r;
  logic dn_lvl_r;
  logic up_prev_r;
  logic dn_prev_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coast_s_r <= 3'h7;
      up_s_r <= 3'h0;
      dn_s_r <= 3'h0;
    end else begin
      coast_s_r <= {coast_s_r[1:0], coast_pin_n};
      up_s_r <= {up_s_r[1:0], speed_up_pin};
      dn_s_r <= {dn_s_r[1:0], speed_down_pin};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coast_pin_low_r <= 1'b0;
      up_lvl_r <= 1'b0;
      dn_lvl_r <= 1'b0;
    end else begin
      if (coast_s_r[2] == coast_s_r[1]) coast_pin_low_r <= ~coast_s_r[2];
      if (up_s_r[2] == up_s_r[1]) up_lvl_r <= up_s_r[2];
      if (dn_s_r[2] == dn_s_r[1]) dn_lvl_r <= dn_s_r[2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_prev_r <= 1'b0;
      dn_prev_r <= 1'b0;
    end else begin
      up_prev_r <= up_lvl_r;
      dn_prev_r <= dn_lvl_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control decode, outputs registered

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preset_sel <= 2'h0;
      dc_brake <= 1'b0;
      coast <= 1'b0;
      quick_stop <= 1'b0;
      freeze <= 1'b0;
      ramp_stop <= 1'b0;
      jog <= 1'b0;
      ref_value <= 16'h0000;
    end else begin
      preset_sel <= ctrl_r[`DCSW_C_PRE_HI:`DCSW_C_PRE_LO];
      dc_brake <= ~ctrl_r[`DCSW_C_DCBRK];
      coast <= ~ctrl_r[`DCSW_C_COAST];
      quick_stop <= ~ctrl_r[`DCSW_C_QSTOP];
      freeze <= ~ctrl_r[`DCSW_C_FREEZE];
      // a held frequency cannot be ramp-stopped by the start bit
      ramp_stop <= ~ctrl_r[`DCSW_C_START] &
                   ctrl_r[`DCSW_C_FREEZE];
      jog <= ctrl_r[`DCSW_C_JOG];
      ref_value <= ref_r;
    end
  end

  // bit 09 has no function and is never looked at

  // held frequency tracks out_freq while bit 05 is high; while it is low, only the speed-up and speed-down inputs move it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      held_freq <= 16'h0000;
    end else if (ctrl_r[`DCSW_C_FREEZE]) begin
      held_freq <= out_freq;
    end else if (up_lvl_r && !up_prev_r && !dn_lvl_r) begin
      held_freq <= held_freq + `DCSW_HOLD_STEP;
    end else if (dn_lvl_r && !dn_prev_r && !up_lvl_r) begin
      held_freq <= held_freq - `DCSW_HOLD_STEP;
    end
  end

  // reset is edge driven across accepted words only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_bit_r <= 1'b0;
      trip_reset <= 1'b0;
    end else begin
      rst_bit_r <= ctrl_r[`DCSW_C_RESET];
      trip_reset <= ctrl_r[`DCSW_C_RESET] & ~rst_bit_r;
    end
  end

  // relays drop on time-out; a word landing in the same cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      relay1 <= 1'b0;
      relay2 <= 1'b0;
    end else if (ctrl_acc) begin
      relay1 <= wdata[`DCSW_C_RELAY1] & cfg_r[`DCSW_G_RELAY1];
      relay2 <= wdata[`DCSW_C_RELAY2] & cfg_r[`DCSW_G_RELAY2];
    end else if (bus_timeout) begin
      relay1 <= 1'b0;
      relay2 <= 1'b0;
    end else begin
      relay1 <= relay1 & cfg_r[`DCSW_G_RELAY1];
      relay2 <= relay2 & cfg_r[`DCSW_G_RELAY2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      setup_sel <= 2'h0;
      reverse <= 1'b0;
    end else begin
      setup_sel <= cfg_r[`DCSW_G_MULTI] ?
                   ctrl_r[`DCSW_C_SET_HI:`DCSW_C_SET_LO] : 2'h0;
      reverse <= ctrl_r[`DCSW_C_REV] & cfg_r[`DCSW_G_REVBUS];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status word
  logic coasting;
  logic start_ok;
  assign coasting = coast_pin_low_r | ~ctrl_r[`DCSW_C_COAST];
  assign start_ok = ~tripped & ~coasting & ctrl_r[`DCSW_C_DCBRK] &
                    ctrl_r[`DCSW_C_QSTOP];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= 16'h0000;
    end else begin
      stat_r <= 16'h0000;
      stat_r[`DCSW_S_CTL_RDY] <= ~tripped;
      stat_r[`DCSW_S_DRV_RDY] <= ~tripped & coasting;
      stat_r[`DCSW_S_STANDBY] <= start_ok;
      stat_r[`DCSW_S_TRIP] <= tripped;
      stat_r[`DCSW_S_TRIPLOCK] <= trip_lock;
      stat_r[`DCSW_S_WARN] <= warning;
      stat_r[`DCSW_S_AT_REF] <= speed_at_ref;
      stat_r[`DCSW_S_SERIAL] <= serial_ok;
      stat_r[`DCSW_S_IN_RANGE] <= freq_in_range;
      stat_r[`DCSW_S_RUNNING] <= running;
      stat_r[`DCSW_S_VOLT] <= volt_warn;
      stat_r[`DCSW_S_CUR_LIM] <= cur_limit;
      stat_r[`DCSW_S_THERM] <= therm_warn;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rst_rise;
    ctrl_acc && wdata[`DCSW_C_RESET] && !ctrl_r[`DCSW_C_RESET];
  endsequence

  sequence s_rst_pulse;
    ##2 trip_reset ##1 !trip_reset;
  endsequence

  a_reset_edge: assert property (s_rst_rise |-> s_rst_pulse)
    else $error("trip reset pulse missing after rising bit");

  a_reset_level: assert property (
    trip_reset |-> $past(ctrl_r[`DCSW_C_RESET]) &&
    !$past(ctrl_r[`DCSW_C_RESET], 2))
    else $error("trip reset without a rising edge");

  a_invalid_ignored: assert property (
    wr && hit(addr, `DCSW_OFS_CTRL) && !wdata[`DCSW_C_VALID] |=>
    $stable(ctrl_r))
    else $error("control word taken with valid bit low");

  a_coast_follow: assert property (
    ctrl_acc |-> ##2 coast == !$past(wdata[`DCSW_C_COAST], 2))
    else $error("coast output does not follow bit 03");

  a_freeze_nostop: assert property (
    freeze |-> !ramp_stop)
    else $error("ramp stop active while frequency held");

  a_timeout_relay: assert property (
    bus_timeout && !ctrl_acc |=> !relay1 && !relay2)
    else $error("relay kept after bus time-out");

  a_relay_cfg: assert property (
    relay1 |-> $past(cfg_r[`DCSW_G_RELAY1]))
    else $error("relay one energised without configuration");

  a_setup_gate: assert property (
    !cfg_r[`DCSW_G_MULTI] |=> setup_sel == 2'h0)
    else $error("setup selected without multi-setup");

  a_status_trip: assert property (
    tripped |=> stat_r[`DCSW_S_TRIP] && !stat_r[`DCSW_S_CTL_RDY] &&
    !stat_r[`DCSW_S_STANDBY])
    else $error("status does not show trip");

  a_status_unused: assert property (
    stat_r[5:4] == 2'h0 && !stat_r[12])
    else $error("unused status bit set");

  a_read_once: assert property (
    rd && addr == `DCSW_OFS_STAT ##1 !rd |=> rdata == 16'h0000)
    else $error("read data stood beyond one cycle");

  a_preset_follow: assert property (
    ctrl_acc |-> ##2 preset_sel ==
    $past(wdata[`DCSW_C_PRE_HI:`DCSW_C_PRE_LO], 2))
    else $error("preset select does not follow bits 01:00");

  a_brake_follow: assert property (
    ctrl_acc |-> ##2 dc_brake == !$past(wdata[`DCSW_C_DCBRK], 2))
    else $error("brake output does not follow bit 02");

  a_qstop_follow: assert property (
    ctrl_acc |-> ##2 quick_stop == !$past(wdata[`DCSW_C_QSTOP], 2))
    else $error("quick stop does not follow bit 04");

  // only a fresh speed input edge may move a held frequency
  a_held_steady: assert property (
    !ctrl_r[`DCSW_C_FREEZE] && !(up_lvl_r && !up_prev_r) &&
    !(dn_lvl_r && !dn_prev_r) |=> $stable(held_freq))
    else $error("held frequency moved without a speed input");

  a_ramp_stop: assert property (
    !ctrl_r[`DCSW_C_START] && ctrl_r[`DCSW_C_FREEZE] |=> ramp_stop)
    else $error("ramp stop missing with start bit low");

  a_jog_follow: assert property (
    ctrl_r[`DCSW_C_JOG] |=> jog)
    else $error("jog output missing with bit 08 high");

  a_setup_follow: assert property (
    cfg_r[`DCSW_G_MULTI] |=>
    setup_sel == $past(ctrl_r[`DCSW_C_SET_HI:`DCSW_C_SET_LO]))
    else $error("setup select does not follow bits 14:13");

  a_reverse_gate: assert property (
    reverse |-> $past(cfg_r[`DCSW_G_REVBUS]))
    else $error("reversing without bus source configured");

  a_status_coast: assert property (
    !tripped && !ctrl_r[`DCSW_C_COAST] |=>
    stat_r[`DCSW_S_DRV_RDY] && !stat_r[`DCSW_S_STANDBY])
    else $error("status does not show a commanded coast");

  a_status_warn: assert property (
    warning |=> stat_r[`DCSW_S_WARN])
    else $error("status does not show a warning");

  a_status_run: assert property (
    serial_ok && running |=> stat_r[`DCSW_S_SERIAL] &&
    stat_r[`DCSW_S_RUNNING])
    else $error("status does not show serial control or running");

endmodule

// >>> test/dcsw_master.sv
`timescale 1ns/1ps
module dcsw_master (
  input wire logic clk,
  output dcsw_pkg::dcsw_addr_t addr,
  output dcsw_pkg::dcsw_word_t wdata,
  output logic wr,
  output logic rd,
  input wire dcsw_pkg::dcsw_word_t rdata
);
  import dcsw_pkg::*;
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // released lines show the inverse so stale values cannot pass
  task automatic put(input dcsw_addr_t a, input dcsw_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic get(input dcsw_addr_t a, output dcsw_word_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
  task automatic telegram(input dcsw_word_t c, input dcsw_word_t r);
    put(8'h00, c);
    put(8'h04, r);
  endtask
endmodule

// >>> test/drive_control_status_word_tb_top.sv
`timescale 1ns/1ps
module drive_control_status_word_tb_top;
  import dcsw_pkg::*;
  typedef struct {dcsw_word_t w; logic [12:0] e;} dcsw_row_t;
  typedef struct {logic [10:0] i; dcsw_word_t e;} dcsw_srow_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  dcsw_addr_t addr;
  dcsw_word_t wdata, rdata, out_freq, held_freq, ref_value, d;
  logic wr, rd, bus_timeout, trip_reset;
  logic [1:0] spd;
  logic [10:0] sin;
  wire [12:0] ov;
  int mismatches = 0;
  int samples_checked = 0;
  // {preset, brake, coast, qstop, freeze, rstop, jog, rly1, rly2, setup, rev}
  dcsw_row_t rows [5] = '{'{16'h047F, 13'h1800}, '{16'h0400, 13'h0780},
    '{16'h0420, 13'h0740}, '{16'hFD61, 13'h0F3F}, '{16'h4E5E, 13'h1094}};
  dcsw_srow_t srows [3] = '{'{11'h001, 16'h0005}, '{11'h701, 16'h00C8},
    '{11'h0FE, 16'hEF03}};
  dcsw_word_t tw [5] = '{16'h0480, 16'h0480, 16'h0400, 16'h3B7F, 16'h0480};
  logic te [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  always #50 clk = ~clk;
  dcsw_master m (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  dcsw_core DUT (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .coast_pin_n(sin[0]), .speed_up_pin(spd[0]),
    .speed_down_pin(spd[1]), .tripped(sin[10]), .trip_lock(sin[9]),
    .warning(sin[8]), .speed_at_ref(sin[7]), .serial_ok(sin[6]),
    .freq_in_range(sin[5]), .running(sin[4]), .volt_warn(sin[3]),
    .cur_limit(sin[2]), .therm_warn(sin[1]), .bus_timeout(bus_timeout),
    .out_freq(out_freq), .preset_sel(ov[12:11]), .dc_brake(ov[10]),
    .coast(ov[9]), .quick_stop(ov[8]), .freeze(ov[7]),
    .held_freq(held_freq), .ramp_stop(ov[6]), .trip_reset(trip_reset),
    .jog(ov[5]), .relay1(ov[4]), .relay2(ov[3]), .setup_sel(ov[2:1]),
    .reverse(ov[0]), .ref_value(ref_value)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sin = 11'h001;
    spd = 2'b00;
    bus_timeout = 1'b0;
    out_freq = 16'h1234;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    chk({3'b0, ov}, 16'h0780);
    m.put(8'h10, 16'h000F);
    foreach (rows[i]) begin
      m.telegram(rows[i].w, 16'h2000);
      tick(1);
      chk({3'b0, ov}, {3'b0, rows[i].e});
      chk({3'b0, ov}, {3'b0, rows[i].e});
    end
    foreach (srows[i]) begin
      @(posedge clk) sin <= srows[i].i;
      tick(6);
      m.get(8'h08, d);
      chk(d, srows[i].e);
    end
    m.get(8'h0C, d);
    chk(d, 16'h1234);
    m.telegram(16'h0400, 16'hE000);
    tick(2);
    m.get(8'h04, d);
    chk(d, 16'hE000);
    chk(ref_value, 16'hE000);
    m.get(8'h14, d);
    chk(d, 16'h0000);
    // only a rising bit 7 in an accepted word clears a trip
    foreach (tw[i]) begin
      m.put(8'h00, tw[i]);
      tick(1);
      chk({15'b0, trip_reset}, {15'b0, te[i]});
      if (i == 3) begin
        chk({3'b0, ov}, 16'h0780);
      end
      tick(1);
      chk({15'b0, trip_reset}, 16'h0000);
    end
    m.put(8'h00, 16'h1C00);
    tick(1);
    chk({14'b0, ov[4:3]}, 16'h0003);
    @(posedge clk) bus_timeout <= 1'b1;
    @(posedge clk) bus_timeout <= 1'b0;
    #1 chk({14'b0, ov[4:3]}, 16'h0000);
    m.put(8'h10, 16'h0000);
    m.put(8'h00, 16'hFC00);
    tick(2);
    chk({3'b0, ov}, 16'h0780);
    m.put(8'h00, 16'h0420);
    tick(3);
    m.put(8'h00, 16'h0400);
    tick(3);
    @(posedge clk) out_freq <= 16'h2000;
    @(posedge clk) spd <= 2'b01;
    repeat (4) @(posedge clk);
    spd <= 2'b00;
    tick(6);
    chk(held_freq, 16'h1235);
    // a second reset in mid-run must bring back the power-up state
    @(posedge clk) rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    chk({3'b0, ov}, 16'h0780);
    chk(held_freq, 16'h0000);
    m.get(8'h00, d);
    chk(d, 16'h0000);
    test_done();
  end
  // a hang counts against the run
  initial begin
    #3000000;
    mismatches++;
    test_done();
  end
endmodule
